/* design/afc_top.sv */
/*
 * Front-end configuration and status logic of a delta-sigma converter:
 * reference selection and alarm, level shift, burn-out and excitation
 * current settings, shared pins, modulator strobe and filter mode.
 * Assumes an Avalon-MM master with waitrequest and synchronous inputs.
 */
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "afc_map.svh"
module afc_top
#(
    parameter int MOD_DIV       = `AFC_MOD_DIV,
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [4:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output      logic [31:0]         avs_readdata,
    output      logic                avs_waitrequest,
    input  wire logic                ref_low_cmp,
    input  wire logic                conv_start,
    input  wire logic [1:0]          ac_drive,
    input  wire afc_pkg::afc_nib_t   gpio_in,
    output      afc_pkg::afc_nib_t   gpio_out,
    output      afc_pkg::afc_nib_t   gpio_oe,
    output      logic                internal_ref_enable,
    output      logic [1:0]          ref_pos_select,
    output      logic [1:0]          ref_neg_select,
    output      logic                ref_use_internal,
    output      logic                level_shift_voltage,
    output      logic [2:0]          burnout_sel,
    output      logic                burnout_src_pos,
    output      afc_pkg::afc_nib_t   excitation1_route,
    output      afc_pkg::afc_nib_t   excitation2_route,
    output      afc_pkg::afc_nib_t   excitation1_magnitude,
    output      afc_pkg::afc_nib_t   excitation2_magnitude,
    output      logic                mod_sample,
    output      logic [2:0]          filt_mode,
    output      logic [4:0]          filt_rate,
    output      logic                filt_single_cycle,
    output      logic                ref_low_alarm,
    output      logic                cfg_error
);
    import afc_pkg::*;

    localparam int CW = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;

    // The divider cannot count fewer than two clocks per sample
    if (MOD_DIV < 2 || MOD_DIV > 256)
    begin : g_bad_div
        $error("MOD_DIV must lie between 2 and 256");
    end

    afc_bus_state_t state;
    afc_pin_if      pins ();
    logic           wr_fire;
    logic [31:0]    next_readdata;
    logic           pull_down;
    logic [4:0]     rate_reg;
    logic [2:0]     filt_reg;
    logic [CW-1:0]  mod_cnt;
    logic [2:0]     next_filt;
    logic           next_error;
    afc_nib_t       port_con;
    afc_nib_t       port_dir;
    afc_nib_t       port_dat;
    logic           ac_en;

    assign pins.connect  = port_con;
    assign pins.dir      = port_dir;
    assign pins.data     = port_dat;
    assign pins.ac_en    = ac_en;
    assign pins.ac_drive = ac_drive;

    // Bus handshake: one wait cycle, then waitrequest low for one cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= BUS_IDLE;
        else
        begin
            case (state)
                BUS_IDLE: if (avs_read || avs_write) state <= BUS_ACK;
                BUS_ACK:  state <= BUS_IDLE;
                default:  state <= BUS_IDLE;
            endcase
        end
    end

    // Waitrequest idles high so a new request is always held a cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !(state == BUS_IDLE && (avs_read || avs_write));
    end

    // A write lands at the edge where the master sees waitrequest low
    assign wr_fire = (state == BUS_ACK) && avs_write;

    // Read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        if (avs_address == `AFC_REG_REF)
        begin
            next_readdata[`AFC_REF_EN_BIT]       = internal_ref_enable;
            next_readdata[`AFC_REF_POS_LSB +: 2] = ref_pos_select;
            next_readdata[`AFC_REF_NEG_LSB +: 2] = ref_neg_select;
        end
        else if (avs_address == `AFC_REG_BIAS)
        begin
            next_readdata[`AFC_BIAS_LS_BIT]      = level_shift_voltage;
            next_readdata[`AFC_BIAS_BO_LSB +: 3] = burnout_sel;
            next_readdata[`AFC_BIAS_POL_BIT]     = pull_down;
        end
        else if (avs_address == `AFC_REG_EXC)
        begin
            next_readdata[`AFC_EXC_R1_LSB +: 4] = excitation1_route;
            next_readdata[`AFC_EXC_R2_LSB +: 4] = excitation2_route;
            next_readdata[`AFC_EXC_M1_LSB +: 4] = excitation1_magnitude;
            next_readdata[`AFC_EXC_M2_LSB +: 4] = excitation2_magnitude;
        end
        else if (avs_address == `AFC_REG_MODE)
        begin
            next_readdata[`AFC_MODE_RATE_LSB +: 5] = rate_reg;
            next_readdata[`AFC_MODE_FILT_LSB +: 3] = filt_reg;
        end
        else if (avs_address == `AFC_REG_PORT)
        begin
            next_readdata[`AFC_PORT_CON_LSB +: 4] = port_con;
            next_readdata[`AFC_PORT_DIR_LSB +: 4] = port_dir;
            next_readdata[`AFC_PORT_DAT_LSB +: 4] = pins.rd_val;
            next_readdata[`AFC_PORT_AC_BIT]       = ac_en;
        end
        else if (avs_address == `AFC_REG_STAT)
        begin
            next_readdata[`AFC_STAT_ALM_BIT] = ref_low_alarm;
            next_readdata[`AFC_STAT_ERR_BIT] = cfg_error;
        end
    end

    // Read data captured when the request is first seen, stands a cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= 32'h0000_0000;
        else if (state == BUS_IDLE && avs_read)
            avs_readdata <= next_readdata;
    end

    // Reference selection; supply reference is the reset choice
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            internal_ref_enable <= 1'b0;
            ref_pos_select      <= `AFC_REF_SUPPLY;
            ref_neg_select      <= `AFC_REF_SUPPLY;
        end
        else if (wr_fire && avs_address == `AFC_REG_REF)
        begin
            internal_ref_enable <= avs_writedata[`AFC_REF_EN_BIT];
            ref_pos_select      <= avs_writedata[`AFC_REF_POS_LSB +: 2];
            ref_neg_select      <= avs_writedata[`AFC_REF_NEG_LSB +: 2];
        end
    end

    // Internal reference is in use only when both selectors say so
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ref_use_internal <= 1'b0;
        else
            ref_use_internal <= (ref_pos_select == `AFC_REF_INTERNAL) &&
                                (ref_neg_select == `AFC_REF_INTERNAL);
    end

    // Alarm: a low comparator wins over a clearing conversion start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ref_low_alarm <= 1'b0;
        else if (ref_low_cmp)
            ref_low_alarm <= 1'b1;
        else if (conv_start)
            ref_low_alarm <= 1'b0;
    end

    // Level shift and burn-out; out-of-range burn-out codes turn it off
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            level_shift_voltage <= 1'b0;
            burnout_sel         <= 3'h0;
            pull_down           <= 1'b0;
        end
        else if (wr_fire && avs_address == `AFC_REG_BIAS)
        begin
            level_shift_voltage <= avs_writedata[`AFC_BIAS_LS_BIT];
            burnout_sel         <= (avs_writedata[`AFC_BIAS_BO_LSB +: 3] > `AFC_BO_MAX) ?
                                   3'h0 : avs_writedata[`AFC_BIAS_BO_LSB +: 3];
            pull_down           <= avs_writedata[`AFC_BIAS_POL_BIT];
        end
    end

    // Source current to the positive channel only in pull-up polarity
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            burnout_src_pos <= 1'b1;
        else
            burnout_src_pos <= !pull_down;
    end

    // Excitation routes and magnitudes; magnitude codes above the top clamp
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            excitation1_route     <= `AFC_ROUTE_RST;
            excitation2_route     <= `AFC_ROUTE_RST;
            excitation1_magnitude <= 4'h0;
            excitation2_magnitude <= 4'h0;
        end
        else if (wr_fire && avs_address == `AFC_REG_EXC)
        begin
            excitation1_route     <= avs_writedata[`AFC_EXC_R1_LSB +: 4];
            excitation2_route     <= avs_writedata[`AFC_EXC_R2_LSB +: 4];
            excitation1_magnitude <= (avs_writedata[`AFC_EXC_M1_LSB +: 4] > `AFC_MAG_MAX) ?
                                     `AFC_MAG_MAX : avs_writedata[`AFC_EXC_M1_LSB +: 4];
            excitation2_magnitude <= (avs_writedata[`AFC_EXC_M2_LSB +: 4] > `AFC_MAG_MAX) ?
                                     `AFC_MAG_MAX : avs_writedata[`AFC_EXC_M2_LSB +: 4];
        end
    end

    // Rate and filter live together in the mode register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rate_reg <= `AFC_RATE_RST;
            filt_reg <= `AFC_FILT_RST;
        end
        else if (wr_fire && avs_address == `AFC_REG_MODE)
        begin
            rate_reg <= avs_writedata[`AFC_MODE_RATE_LSB +: 5];
            filt_reg <= avs_writedata[`AFC_MODE_FILT_LSB +: 3];
        end
    end

    // Shared-pin settings
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_con <= 4'h0;
            port_dir <= `AFC_DIR_RST;
            port_dat <= 4'h0;
            ac_en    <= 1'b0;
        end
        else if (wr_fire && avs_address == `AFC_REG_PORT)
        begin
            port_con <= avs_writedata[`AFC_PORT_CON_LSB +: 4];
            port_dir <= avs_writedata[`AFC_PORT_DIR_LSB +: 4];
            port_dat <= avs_writedata[`AFC_PORT_DAT_LSB +: 4];
            ac_en    <= avs_writedata[`AFC_PORT_AC_BIT];
        end
    end

    // Filter legalisation: high rates force sinc5, FIR only up to 20 SPS
    always_comb
    begin
        next_error = 1'b0;
        next_filt  = filt_reg;
        if (rate_reg >= `AFC_RATE_SINC5_MIN)
        begin
            next_filt  = `AFC_FILT_SINC5;
            next_error = (filt_reg != `AFC_FILT_SINC5) || (rate_reg > `AFC_RATE_MAX);
        end
        else if (filt_reg == `AFC_FILT_FIR)
        begin
            if (rate_reg > `AFC_RATE_FIR_MAX || rate_reg == `AFC_RATE_GAP)
            begin
                next_filt  = `AFC_FILT_SINC4;
                next_error = 1'b1;
            end
        end
        else if (filt_reg >= `AFC_FILT_SINC5)
        begin
            next_filt  = `AFC_FILT_SINC4;
            next_error = 1'b1;
        end
        if (!LARGE_VARIANT && (ref_pos_select == `AFC_REF_EXT_HIGH ||
                               ref_neg_select == `AFC_REF_EXT_HIGH))
            next_error = 1'b1;
    end

    // Effective filter settings handed to the decimator
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            filt_mode         <= `AFC_FILT_RST;
            filt_rate         <= `AFC_RATE_RST;
            filt_single_cycle <= 1'b1;
            cfg_error         <= 1'b0;
        end
        else
        begin
            filt_mode         <= next_filt;
            filt_rate         <= (rate_reg > `AFC_RATE_MAX) ? `AFC_RATE_MAX : rate_reg;
            filt_single_cycle <= (next_filt == `AFC_FILT_FIR);
            cfg_error         <= next_error;
        end
    end

    // Modulator sample strobe, one clock in every MOD_DIV
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mod_cnt    <= '0;
            mod_sample <= 1'b0;
        end
        else
        begin
            mod_cnt    <= (mod_cnt == CW'(MOD_DIV - 1)) ? '0 : mod_cnt + 1'b1;
            mod_sample <= (mod_cnt == CW'(MOD_DIV - 1));
        end
    end

    afc_gpio u_gpio
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .cfg     (pins.port),
        .pin_in  (gpio_in),
        .pin_out (gpio_out),
        .pin_oe  (gpio_oe)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    alarm_sets_a: assert property ($rose(ref_low_cmp) |=> ref_low_alarm)
        else $error("alarm not set by low reference");

    alarm_holds_a: assert property (ref_low_alarm && !conv_start |=> ref_low_alarm)
        else $error("alarm cleared without conversion start");

    alarm_clears_a: assert property (ref_low_alarm && conv_start && !ref_low_cmp
        |=> !ref_low_alarm)
        else $error("alarm not cleared at conversion start");

    mod_period_a: assert property (mod_sample |=> !mod_sample [*7] ##1 mod_sample)
        else $error("modulator strobe period wrong");

    internal_ref_a: assert property (ref_pos_select == 2'h0 && ref_neg_select == 2'h0
        |=> ref_use_internal)
        else $error("internal reference not chosen");

    burnout_pol_a: assert property (##1 burnout_src_pos == !$past(pull_down))
        else $error("burn-out polarity routing wrong");

    fir_rate_a: assert property (filt_mode == 3'h5 |-> filt_rate <= 5'h04
        && filt_single_cycle)
        else $error("FIR used above its rate range");

    sinc5_high_a: assert property (filt_rate >= 5'h0d |-> filt_mode == 3'h4)
        else $error("high rate without sinc5");

    bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest && state == BUS_IDLE
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest pulse not one cycle");

    bo_range_a: assert property (burnout_sel <= 3'h4)
        else $error("burn-out code out of range");

    read_cov: cover property (state == BUS_ACK && avs_read);
    write_cov: cover property (wr_fire);
    alarm_cov: cover property ($fell(ref_low_alarm));
    ac_cov: cover property (ac_en && gpio_oe != 4'h0);

endmodule : afc_top

/* common/afc_map.svh */
/*
 * Register offsets, field positions, reset values and counts of the
 * analog front-end configuration block.
 * Assumes inclusion by bare name from any file that needs the map.
 */
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH

// Byte offsets of the Avalon-MM registers
`define AFC_REG_REF        5'h00
`define AFC_REG_BIAS       5'h04
`define AFC_REG_EXC        5'h08
`define AFC_REG_MODE       5'h0c
`define AFC_REG_PORT       5'h10
`define AFC_REG_STAT       5'h14

// Field positions (least significant bit of each field)
`define AFC_REF_EN_BIT     0
`define AFC_REF_POS_LSB    1
`define AFC_REF_NEG_LSB    3
`define AFC_BIAS_LS_BIT    0
`define AFC_BIAS_BO_LSB    1
`define AFC_BIAS_POL_BIT   4
`define AFC_EXC_R1_LSB     0
`define AFC_EXC_R2_LSB     4
`define AFC_EXC_M1_LSB     8
`define AFC_EXC_M2_LSB     12
`define AFC_MODE_RATE_LSB  0
`define AFC_MODE_FILT_LSB  5
`define AFC_PORT_CON_LSB   0
`define AFC_PORT_DIR_LSB   4
`define AFC_PORT_DAT_LSB   8
`define AFC_PORT_AC_BIT    12
`define AFC_STAT_ALM_BIT   0
`define AFC_STAT_ERR_BIT   1

// Reference selector codes
`define AFC_REF_INTERNAL   2'h0
`define AFC_REF_SUPPLY     2'h1
`define AFC_REF_EXT_LOW    2'h2
`define AFC_REF_EXT_HIGH   2'h3

// Reset values
`define AFC_ROUTE_RST      4'hf
`define AFC_DIR_RST        4'hf
`define AFC_RATE_RST       5'h04
`define AFC_FILT_RST       3'h5

// Code limits
`define AFC_BO_MAX         3'h4
`define AFC_MAG_MAX        4'ha
`define AFC_RATE_MAX       5'h10
`define AFC_RATE_FIR_MAX   5'h04
`define AFC_RATE_GAP       5'h03
`define AFC_RATE_SINC5_MIN 5'h0d

// Filter codes
`define AFC_FILT_SINC4     3'h3
`define AFC_FILT_SINC5     3'h4
`define AFC_FILT_FIR       3'h5

// Modulator divide ratio
`define AFC_MOD_DIV        8

// Level-shift settling for a 0.1 uF load, in 10 ns clocks
`define AFC_LS_SETTLE_CYC  22000

`endif

/* common/afc_pkg.sv */
/*
 * Types shared by the front-end configuration block.
 * Assumes the map header supplies all numeric constants.
 */
package afc_pkg;

    // Bus slave handshake states
    typedef enum logic {BUS_IDLE, BUS_ACK} afc_bus_state_t;

    typedef logic [3:0] afc_nib_t;

endpackage : afc_pkg

/* common/afc_pin_if.sv */
/*
 * Interface between the register file and the shared-pin port logic.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface afc_pin_if;
    import afc_pkg::*;

    afc_nib_t   connect;
    afc_nib_t   dir;
    afc_nib_t   data;
    logic       ac_en;
    logic [1:0] ac_drive;
    afc_nib_t   rd_val;

    modport ctrl (output connect, output dir, output data, output ac_en,
                  output ac_drive, input rd_val);
    modport port (input connect, input dir, input data, input ac_en,
                  input ac_drive, output rd_val);
endinterface : afc_pin_if

/* design/afc_gpio.sv */
/*
 * Four shared general-purpose pins: connect, direction, data readback
 * and AC-excitation override. All outputs are registered.
 * Assumes pin inputs are synchronous to clk; two stages settle them.
 */
`timescale 1ns/10ps
module afc_gpio
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    afc_pin_if.port           cfg,
    input  wire logic [3:0]   pin_in,
    output      logic [3:0]   pin_out,
    output      logic [3:0]   pin_oe
);
    import afc_pkg::*;

    afc_nib_t meta;
    afc_nib_t sync;
    afc_nib_t drive;

    // Two-stage capture of the pin levels; only sync reads meta
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= 4'h0;
            sync <= 4'h0;
        end
        else
        begin
            meta <= pin_in;
            sync <= meta;
        end
    end

    // Pins 0 and 2 carry the first AC phase, pins 1 and 3 the second
    always_comb
    begin
        drive = cfg.ac_en ? {cfg.ac_drive, cfg.ac_drive} : cfg.data;
    end

    // Pin drivers; an unconnected pin is never driven
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out <= 4'h0;
            pin_oe  <= 4'h0;
        end
        else
        begin
            pin_out <= drive;
            pin_oe  <= cfg.connect & ~cfg.dir;
        end
    end

    // Outputs read back written data, inputs read the settled level
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cfg.rd_val <= 4'h0;
        else
            cfg.rd_val <= (cfg.dir & sync) | (~cfg.dir & cfg.data);
    end

    oe_needs_connect_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pin_oe & ~$past(cfg.connect)) == 4'h0)
        else $error("pin driven while not connected");

    input_undriven_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pin_oe & $past(cfg.dir)) == 4'h0)
        else $error("input pin is driven");

    ac_override_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(cfg.ac_en) |-> pin_out == {2{$past(cfg.ac_drive)}})
        else $error("ac drive did not override port data");

endmodule : afc_gpio

/* dv/afc_host.sv */
/* Host model: Avalon-MM master that programs the front end.
   Assumes one clock shared with the slave; bench calls xfer. */
`timescale 1ns/10ps
module afc_host
(
    input  wire logic        clk,
    output      logic [4:0]  avs_address,
    output      logic        avs_read,
    output      logic        avs_write,
    output      logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // Idle bus from time zero
    initial
    begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end

    // Request held until waitrequest is seen low; bench timeout bounds it
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
endmodule : afc_host

/* dv/afc_tb.sv */
/* Self-checking bench of the front-end block.
   Assumes the host model drives the register bus. */
`timescale 1ns/10ps
`include "afc_map.svh"
module testbench;
    import afc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address, filt_rate;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic ref_low_cmp = 1'b0, conv_start = 1'b0, internal_ref_enable, ref_use_internal;
    logic [1:0] ac_drive = 2'h0, ref_pos_select, ref_neg_select;
    logic level_shift_voltage, burnout_src_pos, mod_sample, filt_single_cycle;
    logic ref_low_alarm, cfg_error;
    logic [2:0] burnout_sel, filt_mode;
    afc_nib_t gpio_in, gpio_out, gpio_oe, excitation1_route, excitation2_route;
    afc_nib_t excitation1_magnitude, excitation2_magnitude;
    int error_cnt = 0, compares = 0, cyc = 0, n;

    // Pins not driven by the block carry an outside pattern
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & 4'ha);
    always #5 clk = ~clk;
    afc_top afc_top_inst (.*);
    afc_host afc_host_inst (.*);

    // Hang guard; the level-shift settling wait dominates the run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        afc_host_inst.xfer(1'b1, a, d, q);
        tick(3);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        afc_host_inst.xfer(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Reset values and reference selection
    task automatic t_ref();
        rd(`AFC_REG_REF);
        chk("ref_rst", q, 32'h0a);
        rd(`AFC_REG_MODE);
        chk("mode_rst", q, 32'ha4);
        wr(`AFC_REG_REF, 32'h01); // internal ref on before excitation
        chk("use_int", ref_use_internal, 1'b1);
        chk("ref_en", internal_ref_enable, 1'b1);
        wr(`AFC_REG_REF, 32'h15);
        chk("pos10", {ref_pos_select, ref_neg_select}, 4'ha);
        wr(`AFC_REG_REF, 32'h1f);
        chk("pos11", {ref_pos_select, ref_neg_select, ref_use_internal}, 5'h1e);
    endtask : t_ref

    // Alarm is sticky and read-only until a conversion start clears it
    task automatic t_alarm();
        ref_low_cmp <= 1'b1;
        tick(2);
        ref_low_cmp <= 1'b0;
        rd(`AFC_REG_STAT);
        chk("alm_set", q, 32'h1);
        wr(`AFC_REG_STAT, 32'h0);
        chk("alm_ro", ref_low_alarm, 1'b1);
        conv_start <= 1'b1;
        tick(1);
        conv_start <= 1'b0;
        tick(2);
        chk("alm_clr", ref_low_alarm, 1'b0);
    endtask : t_alarm

    // Burn-out, level shift with its settling wait, excitation sources
    task automatic t_bias();
        wr(`AFC_REG_BIAS, 32'h18);
        chk("bo_dn", {burnout_sel, burnout_src_pos}, 4'h8);
        wr(`AFC_REG_BIAS, 32'h07);
        chk("bo_up", {level_shift_voltage, burnout_sel, burnout_src_pos}, 5'h17);
        tick(`AFC_LS_SETTLE_CYC);
        conv_start <= 1'b1;
        tick(1);
        conv_start <= 1'b0;
        tick(2);
        chk("alm_idle", ref_low_alarm, 1'b0);
        wr(`AFC_REG_EXC, 32'h3c21);
        chk("exc_rt", {excitation2_route, excitation1_route}, 8'h21);
        chk("exc_mag", {excitation2_magnitude, excitation1_magnitude}, 8'h3a);
    endtask : t_bias

    // Shared pins: drive, readback and AC override
    task automatic t_port();
        wr(`AFC_REG_PORT, 32'h05cf);
        chk("oe", gpio_oe, 4'h3);
        chk("out", gpio_out, 4'h5);
        tick(4);
        rd(`AFC_REG_PORT);
        chk("port_rd", q, 32'h09cf);
        ac_drive <= 2'h2;
        wr(`AFC_REG_PORT, 32'h15cf);
        chk("ac_out", gpio_out, 4'ha);
        wr(`AFC_REG_PORT, 32'h0000);
        chk("no_con", gpio_oe, 4'h0);
    endtask : t_port

    // Modulator strobe: ten pulses in any eighty clocks
    task automatic t_mod();
        n = 0;
        repeat (80)
        begin
            @(posedge clk);
            n += (mod_sample === 1'b1);
        end
        chk("mod_cnt", n, 10);
    endtask : t_mod

    // Filter mode and rate legalisation
    task automatic t_filt();
        wr(`AFC_REG_MODE, 32'h90);
        chk("sinc5", {filt_mode, filt_rate, cfg_error}, 9'h120);
        wr(`AFC_REG_MODE, 32'ha2);
        chk("fir", {filt_mode, filt_single_cycle, cfg_error}, 5'h16);
        wr(`AFC_REG_MODE, 32'ha5);
        chk("fir_bad", cfg_error, 1'b1);
    endtask : t_filt

    // Reset, then every scenario in turn
    initial
    begin
        tick(16);
        rst_b <= 1'b1;
        t_ref();
        t_alarm();
        t_bias();
        t_port();
        t_mod();
        t_filt();
        report_and_stop();
    end
endmodule : testbench
